//--- verilog/wsc_top.sv
// wake-up line unit: stop-entry sequence, wake-up lines, top-level pin, apb slave
// How it works
// - writing 1,0,1 to stop bit in three writes sets it and requests stop
// - entry needs pin low, wake-up mode, no unmasked pending, one mask set
// - any other register write mid-sequence aborts; whole sequence must repeat
// - unmasked line wake-up while stopped clears the stop bit, unless the pin rises in the same cycle
// - pin rising edge wake-up leaves stop bit at one
// - stop bit reads one after first write and after a good third write
// - pin high through good sequence: no stop, bit one, exit flag zero
// - internal stop request ORed with active-low external stop pin
// - any of sixteen unmasked lines ends stop, clock restarts after delay
// - pin rising edge also ends stop, as a seventeenth line
// - exit flag set after real exit until cleared; zero when entry filtered
// - unmasked line event mid-sequence blocks entry; at or after the third write it leaves bit and flag zero
// - pin rising edge mid-sequence is an interrupt and blocks entry
// - with edge select, pin rise sets top pending; request if nm or enables
// - non-maskable select clears only by reset; each request needs new edge
// - pin already high gives no interrupt and no stop; low before third enters
// - pending clears work even while the line stays active
// - clearing some pending bits with others left gives a fresh channel edge
// - source select bit 1 routes sixteen lines onto the shared channel
// - mode bit 0 gives interrupt mode, 1 gives stop-exit wake-up mode
// - pending set on falling edge when polarity 0, rising when 1; sw writable
// - masked line gives neither wake-up nor channel interrupt
`timescale 1ns/1ps
module wsc_top #(
    parameter int LINES = 16,
    parameter int OSC_CYCLES = wsc_pkg::OSC_START_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [wsc_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [LINES-1:0] wakeup_line_i,
    input wire logic nmi_i,
    input wire logic ext_stop_n_i,
    input wire logic cpu_write_i,
    output logic stop_request_o,
    output logic clock_run_o,
    output logic shared_line_interrupt_channel_o,
    output logic top_level_irq_o
);
    localparam int HALF = LINES / 2;

    wsc_pkg::wsc_state_e state_q;
    logic [7:0] control_q;
    logic [LINES-1:0] mask_q, pol_q, pend_q, line_q;
    logic nmi_q, tl_edge_q, tl_pend_q, tl_nm_q, tl_en_q, gie_q;
    logic exit_flag_q, ch_q, ch_pend_q;
    logic [3:0] entry_cnt_q;
    logic [$clog2(OSC_CYCLES+1)-1:0] osc_cnt_q;
    logic [31:0] rdata_d;

    function automatic logic hit(input logic [wsc_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a == wsc_pkg::ADDR_W'({idx, 2'b00}));
    endfunction

    logic acc, wr, rd_ok, wr_ctl, stop_wr_val;
    logic [7:0] wbyte;
    assign acc = psel_i & penable_i;
    assign wr = acc & pwrite_i & pstrb_i[0];
    assign wbyte = pwdata_i[7:0];
    assign wr_ctl = wr & hit(paddr_i, wsc_pkg::IDX_CONTROL);
    assign stop_wr_val = wbyte[wsc_pkg::BIT_STOP];
    assign pready_o = 1'b1;
    assign rd_ok = hit(paddr_i, wsc_pkg::IDX_CONTROL) | hit(paddr_i, wsc_pkg::IDX_MASK_HIGH)
        | hit(paddr_i, wsc_pkg::IDX_MASK_LOW) | hit(paddr_i, wsc_pkg::IDX_POL_HIGH)
        | hit(paddr_i, wsc_pkg::IDX_POL_LOW) | hit(paddr_i, wsc_pkg::IDX_PEND_HIGH)
        | hit(paddr_i, wsc_pkg::IDX_PEND_LOW) | hit(paddr_i, wsc_pkg::IDX_TOP_LEVEL)
        | hit(paddr_i, wsc_pkg::IDX_STATUS);
    assign pslverr_o = acc & ~rd_ok;

    // edge detection on lines and the top-level pin
    logic [LINES-1:0] line_evt, armed;
    logic nmi_rise, any_wake, line_wr;
    assign line_evt = pol_q & wakeup_line_i & ~line_q | ~pol_q & ~wakeup_line_i & line_q;
    assign nmi_rise = nmi_i & ~nmi_q;
    assign armed = pend_q & mask_q;
    assign any_wake = control_q[wsc_pkg::BIT_MODE] & (|armed);
    // polarity writes swallow coincident edges
    assign line_wr = wr & (hit(paddr_i, wsc_pkg::IDX_POL_HIGH) | hit(paddr_i, wsc_pkg::IDX_POL_LOW));

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            line_q <= '0;
            nmi_q <= 1'b0;
        end
        else
        begin
            line_q <= wakeup_line_i;
            nmi_q <= nmi_i;
        end
    end

    // entry checks, sampled at the third write
    logic entry_ok, other_write, seq_break;
    assign entry_ok = ~nmi_i & control_q[wsc_pkg::BIT_MODE] & ~(|armed) & (|mask_q);
    assign other_write = (wr & ~wr_ctl) | cpu_write_i;
    assign seq_break = other_write | (|(line_evt & mask_q)) | nmi_rise;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state_q <= wsc_pkg::WSC_IDLE;
            entry_cnt_q <= '0;
            osc_cnt_q <= '0;
        end
        else
        begin
            unique case (state_q)
                wsc_pkg::WSC_IDLE:
                begin
                    if (wr_ctl & stop_wr_val)
                    begin
                        state_q <= wsc_pkg::WSC_GOT1;
                    end
                end
                wsc_pkg::WSC_GOT1:
                begin
                    if (seq_break)
                    begin
                        state_q <= wsc_pkg::WSC_IDLE;
                    end
                    else if (wr_ctl)
                    begin
                        state_q <= stop_wr_val ? wsc_pkg::WSC_GOT1 : wsc_pkg::WSC_GOT0;
                    end
                end
                wsc_pkg::WSC_GOT0:
                begin
                    if (seq_break | (wr_ctl & ~stop_wr_val))
                    begin
                        state_q <= wsc_pkg::WSC_IDLE;
                    end
                    else if (wr_ctl & entry_ok)
                    begin
                        state_q <= wsc_pkg::WSC_ENTER;
                        entry_cnt_q <= wsc_pkg::ENTRY_CYC;
                    end
                    else if (wr_ctl)
                    begin
                        state_q <= wsc_pkg::WSC_IDLE;
                    end
                end
                wsc_pkg::WSC_ENTER:
                begin
                    // a control write in the settling window is a write like any other
                    if (seq_break | wr_ctl)
                    begin
                        state_q <= wsc_pkg::WSC_IDLE;
                    end
                    else if (entry_cnt_q == 4'h1)
                    begin
                        state_q <= wsc_pkg::WSC_STOP;
                        osc_cnt_q <= '0;
                    end
                    else
                    begin
                        entry_cnt_q <= entry_cnt_q - 4'h1;
                    end
                end
                wsc_pkg::WSC_STOP:
                begin
                    if (any_wake | nmi_rise | (osc_cnt_q != '0))
                    begin
                        // oscillator restart delay before the clock runs again
                        if (osc_cnt_q == $bits(osc_cnt_q)'(OSC_CYCLES))
                        begin
                            state_q <= wsc_pkg::WSC_IDLE;
                        end
                        else
                        begin
                            osc_cnt_q <= osc_cnt_q + $bits(osc_cnt_q)'(1);
                        end
                    end
                end
            endcase
        end
    end

    logic in_stop, wake_now;
    assign in_stop = (state_q == wsc_pkg::WSC_STOP);
    assign wake_now = in_stop & (osc_cnt_q == '0) & (any_wake | nmi_rise);
    assign stop_request_o = in_stop | ~ext_stop_n_i;
    assign clock_run_o = ~in_stop;

    // control register with hardware-owned stop bit
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            control_q <= wsc_pkg::CONTROL_RESET;
        end
        else
        begin
            if (wr_ctl)
            begin
                control_q[wsc_pkg::BIT_MODE] <= wbyte[wsc_pkg::BIT_MODE];
                control_q[wsc_pkg::BIT_SRC] <= wbyte[wsc_pkg::BIT_SRC];
            end
            if (wake_now & any_wake & ~nmi_rise)
            begin
                control_q[wsc_pkg::BIT_STOP] <= 1'b0;
            end
            else if (wake_now)
            begin
                control_q[wsc_pkg::BIT_STOP] <= 1'b1;
            end
            else if (state_q == wsc_pkg::WSC_GOT0 && wr_ctl && stop_wr_val)
            begin
                // third write: bit stays set only when correct, even with pin high
                control_q[wsc_pkg::BIT_STOP] <= ~seq_break & (entry_ok | nmi_i);
            end
            else if (state_q == wsc_pkg::WSC_ENTER && (seq_break | wr_ctl))
            begin
                control_q[wsc_pkg::BIT_STOP] <= 1'b0;
            end
            else if (wr_ctl)
            begin
                control_q[wsc_pkg::BIT_STOP] <= stop_wr_val & ~seq_break;
            end
            else if (state_q != wsc_pkg::WSC_IDLE && state_q != wsc_pkg::WSC_STOP && seq_break)
            begin
                control_q[wsc_pkg::BIT_STOP] <= 1'b0;
            end
        end
    end

    // line registers: pending set wins over a software clear
    logic [LINES-1:0] pend_wdata, pend_wmask;
    always_comb
    begin
        pend_wdata = pend_q;
        pend_wmask = '0;
        if (wr & hit(paddr_i, wsc_pkg::IDX_PEND_LOW))
        begin
            pend_wdata[HALF-1:0] = wbyte[HALF-1:0];
            pend_wmask[HALF-1:0] = '1;
        end
        if (wr & hit(paddr_i, wsc_pkg::IDX_PEND_HIGH))
        begin
            pend_wdata[LINES-1:HALF] = wbyte[HALF-1:0];
            pend_wmask[LINES-1:HALF] = '1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            mask_q <= {2{wsc_pkg::LINE_RESET}};
            pol_q <= {2{wsc_pkg::LINE_RESET}};
            pend_q <= {2{wsc_pkg::LINE_RESET}};
        end
        else
        begin
            if (wr & hit(paddr_i, wsc_pkg::IDX_MASK_LOW)) mask_q[HALF-1:0] <= wbyte[HALF-1:0];
            if (wr & hit(paddr_i, wsc_pkg::IDX_MASK_HIGH)) mask_q[LINES-1:HALF] <= wbyte[HALF-1:0];
            if (wr & hit(paddr_i, wsc_pkg::IDX_POL_LOW)) pol_q[HALF-1:0] <= wbyte[HALF-1:0];
            if (wr & hit(paddr_i, wsc_pkg::IDX_POL_HIGH)) pol_q[LINES-1:HALF] <= wbyte[HALF-1:0];
            // clears act on the stored bit, not the line level
            pend_q <= (pend_wmask & pend_wdata | ~pend_wmask & pend_q)
                | (line_evt & {LINES{~line_wr}});
        end
    end

    // shared channel: level of any armed line, pending on its rising edge
    logic ch_d;
    assign ch_d = control_q[wsc_pkg::BIT_SRC] & (|armed);
    logic clr_some;
    assign clr_some = |(pend_wmask & pend_q & ~pend_wdata & mask_q);

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ch_q <= 1'b0;
            ch_pend_q <= 1'b0;
        end
        else
        begin
            // a partial clear drops the level for one cycle to make a fresh edge
            ch_q <= ch_d & ~clr_some;
            if (ch_d & ~clr_some & ~ch_q)
            begin
                ch_pend_q <= 1'b1;
            end
            else if (wr & hit(paddr_i, wsc_pkg::IDX_STATUS) & wbyte[wsc_pkg::BIT_CH_PEND])
            begin
                ch_pend_q <= 1'b0;
            end
        end
    end
    assign shared_line_interrupt_channel_o = ch_pend_q;

    // top-level pin logic and exit flag
    logic tl_wr;
    assign tl_wr = wr & hit(paddr_i, wsc_pkg::IDX_TOP_LEVEL);
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            tl_edge_q <= 1'b0;
            tl_pend_q <= 1'b0;
            tl_nm_q <= 1'b0;
            tl_en_q <= 1'b0;
            gie_q <= 1'b0;
            exit_flag_q <= 1'b0;
        end
        else
        begin
            if (tl_wr)
            begin
                tl_edge_q <= wbyte[wsc_pkg::BIT_TL_EDGE];
                tl_en_q <= wbyte[wsc_pkg::BIT_TL_EN];
                gie_q <= wbyte[wsc_pkg::BIT_GIE];
                tl_nm_q <= tl_nm_q | wbyte[wsc_pkg::BIT_TL_NM];
            end
            if (tl_edge_q & nmi_rise)
            begin
                tl_pend_q <= 1'b1;
            end
            else if (tl_wr & ~wbyte[wsc_pkg::BIT_TL_PEND])
            begin
                tl_pend_q <= 1'b0;
            end
            if (wake_now)
            begin
                exit_flag_q <= 1'b1;
            end
            else if (wr & hit(paddr_i, wsc_pkg::IDX_STATUS) & wbyte[wsc_pkg::BIT_EXIT])
            begin
                exit_flag_q <= 1'b0;
            end
        end
    end
    assign top_level_irq_o = tl_pend_q & (tl_nm_q | (tl_en_q & gie_q));

    always_comb
    begin
        rdata_d = '0;
        if (hit(paddr_i, wsc_pkg::IDX_CONTROL)) rdata_d[7:0] = {5'h00, control_q[2:0]};
        if (hit(paddr_i, wsc_pkg::IDX_MASK_LOW)) rdata_d[HALF-1:0] = mask_q[HALF-1:0];
        if (hit(paddr_i, wsc_pkg::IDX_MASK_HIGH)) rdata_d[HALF-1:0] = mask_q[LINES-1:HALF];
        if (hit(paddr_i, wsc_pkg::IDX_POL_LOW)) rdata_d[HALF-1:0] = pol_q[HALF-1:0];
        if (hit(paddr_i, wsc_pkg::IDX_POL_HIGH)) rdata_d[HALF-1:0] = pol_q[LINES-1:HALF];
        if (hit(paddr_i, wsc_pkg::IDX_PEND_LOW)) rdata_d[HALF-1:0] = pend_q[HALF-1:0];
        if (hit(paddr_i, wsc_pkg::IDX_PEND_HIGH)) rdata_d[HALF-1:0] = pend_q[LINES-1:HALF];
        if (hit(paddr_i, wsc_pkg::IDX_TOP_LEVEL))
            rdata_d[4:0] = {gie_q, tl_en_q, tl_nm_q, tl_pend_q, tl_edge_q};
        if (hit(paddr_i, wsc_pkg::IDX_STATUS))
            rdata_d[3:0] = {nmi_i, ch_pend_q, in_stop, exit_flag_q};
    end

    // registered read data, valid in the access phase
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            prdata_o <= '0;
        end
        else if (psel_i & ~penable_i & ~pwrite_i)
        begin
            prdata_o <= rdata_d;
        end
    end
endmodule // wsc_top

//--- verilog/wsc_pkg.sv
// package: register map, fields and timing counts for the wake-up stop-entry block
package wsc_pkg;
    // printed offsets 0xf9.. are not all multiples of four: they are indices
    localparam logic [7:0] IDX_CONTROL = 8'hf9;
    localparam logic [7:0] IDX_MASK_HIGH = 8'hfa;
    localparam logic [7:0] IDX_MASK_LOW = 8'hfb;
    localparam logic [7:0] IDX_POL_HIGH = 8'hfc;
    localparam logic [7:0] IDX_POL_LOW = 8'hfd;
    localparam logic [7:0] IDX_PEND_HIGH = 8'hfe;
    localparam logic [7:0] IDX_PEND_LOW = 8'hff;
    localparam logic [7:0] IDX_TOP_LEVEL = 8'hf0;
    localparam logic [7:0] IDX_STATUS = 8'hf1;
    localparam int ADDR_W = 12;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] LINE_RESET = 8'h00;
    localparam int BIT_MODE = 0;
    localparam int BIT_SRC = 1;
    localparam int BIT_STOP = 2;
    // top-level register fields
    localparam int BIT_TL_EDGE = 0;
    localparam int BIT_TL_PEND = 1;
    localparam int BIT_TL_NM = 2;
    localparam int BIT_TL_EN = 3;
    localparam int BIT_GIE = 4;
    // status register fields
    localparam int BIT_EXIT = 0;
    localparam int BIT_IN_STOP = 1;
    localparam int BIT_CH_PEND = 2;
    localparam int BIT_NMI_PIN = 3;
    // entry settling window after a correct sequence
    localparam int ENTRY_NS = 24;
    localparam int CLK_NS = 8;
    localparam logic [3:0] ENTRY_CYC = 4'((ENTRY_NS + CLK_NS - 1) / CLK_NS);
    localparam int OSC_START_US = 1;
    localparam int OSC_START_CYC = OSC_START_US * 1000 / CLK_NS;
    typedef enum logic [4:0] {
        WSC_IDLE = 5'h01,
        WSC_GOT1 = 5'h02,
        WSC_GOT0 = 5'h04,
        WSC_ENTER = 5'h08,
        WSC_STOP = 5'h10
    } wsc_state_e;
endpackage

//--- dv/wsc_checker.sv
// port-level assertions for the wake-up stop-entry block
`timescale 1ns/1ps
module wsc_checker #(
    parameter int LINES = 16,
    parameter int OSC_CYCLES = wsc_pkg::OSC_START_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [wsc_pkg::ADDR_W-1:0] paddr_i,
    input wire logic pslverr_o,
    input wire logic nmi_i,
    input wire logic ext_stop_n_i,
    input wire logic cpu_write_i,
    input wire logic stop_request_o,
    input wire logic clock_run_o,
    input wire logic top_level_irq_o
);
    logic [7:0] low_q;
    logic [3:0] ctl_q;
    logic ctl_wr;
    logic mapped;
    assign ctl_wr = psel_i && penable_i && pwrite_i
        && paddr_i == {2'b00, wsc_pkg::IDX_CONTROL, 2'b00};
    assign mapped = paddr_i[1:0] == 2'b00 && paddr_i[11:10] == 2'b00
        && paddr_i[9:2] inside {wsc_pkg::IDX_CONTROL, wsc_pkg::IDX_MASK_HIGH,
        wsc_pkg::IDX_MASK_LOW, wsc_pkg::IDX_POL_HIGH, wsc_pkg::IDX_POL_LOW,
        wsc_pkg::IDX_PEND_HIGH, wsc_pkg::IDX_PEND_LOW, wsc_pkg::IDX_TOP_LEVEL,
        wsc_pkg::IDX_STATUS};
    // saturating: long stops must not wrap into a false short count
    always_ff @(posedge clk_i)
    begin
        if (reset_i || clock_run_o)
            low_q <= 8'h00;
        else if (low_q != 8'hff)
            low_q <= low_q + 8'h01;
    end
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            ctl_q <= 4'hf;
        else if (ctl_wr)
            ctl_q <= 4'h0;
        else if (ctl_q != 4'hf)
            ctl_q <= ctl_q + 4'h1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_ext_stop_or: assert property (
        !ext_stop_n_i |-> stop_request_o)
        else $error("stop pin low without stop request");
    a_stop_holds_req: assert property (
        !clock_run_o |-> stop_request_o)
        else $error("clock stopped without stop request");
    a_reset_run: assert property (disable iff (1'b0)
        reset_i |=> clock_run_o && (stop_request_o == !ext_stop_n_i))
        else $error("reset left the block stopped");
    a_unmapped_err: assert property (
        psel_i && penable_i |-> pslverr_o == !mapped)
        else $error("error response wrong for address");
    a_osc_delay: assert property (
        $rose(clock_run_o) |-> low_q >= 8'(OSC_CYCLES))
        else $error("clock restarted before start-up delay");
    a_entry_nmi_low: assert property (
        $fell(clock_run_o) |-> $past(nmi_i) == 1'b0)
        else $error("stop entered with pin high");
    a_entry_no_write: assert property (
        $fell(clock_run_o) |-> $past(cpu_write_i) == 1'b0)
        else $error("stop entered across a register write");
    a_entry_after_ctl: assert property (
        $fell(clock_run_o) |-> ctl_q <= 4'h8)
        else $error("stop entered without a recent control write");
    a_irq_cause: assert property (
        $rose(top_level_irq_o) |-> $past(nmi_i) || $past(psel_i && penable_i && pwrite_i))
        else $error("top-level request without edge or write");
    c_entry: cover property ($fell(clock_run_o));
    c_wake: cover property ($rose(clock_run_o));
    c_refused: cover property (psel_i && penable_i && pslverr_o);
endmodule // wsc_checker

bind wsc_top wsc_checker #(.LINES(LINES), .OSC_CYCLES(OSC_CYCLES)) u_wsc_checker (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pslverr_o(pslverr_o), .nmi_i(nmi_i),
    .ext_stop_n_i(ext_stop_n_i), .cpu_write_i(cpu_write_i),
    .stop_request_o(stop_request_o), .clock_run_o(clock_run_o),
    .top_level_irq_o(top_level_irq_o));

//--- dv/wsc_partner.sv
// clock unit and interrupt-side partner model
`timescale 1ns/1ps
module wsc_partner (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clock_run_i,
    input wire logic ack_i,
    output logic cpu_write_o,
    output int entries_o
);
    logic run_q;
    // a halted cpu cannot acknowledge, so its write is gated
    assign cpu_write_o = ack_i & clock_run_i;
    always_ff @(posedge clk_i)
    begin
        run_q <= clock_run_i;
        if (reset_i)
            entries_o <= 0;
        else if (run_q && !clock_run_i)
            entries_o <= entries_o + 1;
    end
endmodule // wsc_partner

//--- dv/wsc_top_tb.sv
// self-checking bench for the wake-up stop-entry block
`timescale 1ns/1ps
module wsc_top_tb;
    localparam int OSC = 4;
    localparam logic [7:0] CT = wsc_pkg::IDX_CONTROL;
    localparam logic [7:0] ML = wsc_pkg::IDX_MASK_LOW;
    localparam logic [7:0] MH = wsc_pkg::IDX_MASK_HIGH;
    localparam logic [7:0] PL = wsc_pkg::IDX_PEND_LOW;
    localparam logic [7:0] PH = wsc_pkg::IDX_PEND_HIGH;
    localparam logic [7:0] ST = wsc_pkg::IDX_STATUS;
    localparam logic [7:0] TP = wsc_pkg::IDX_TOP_LEVEL;
    logic clk_i = 1'b0;
    logic reset_i, psel, pen, pwr, nmi, xs_n, ack, rdy, err, sreq, crun, chan, tirq, cpw, e;
    logic [11:0] pa;
    logic [31:0] pwd, prd;
    logic [3:0] pst;
    logic [15:0] ln_v, m16;
    logic [7:0] r;
    logic [7:0] ix[9];
    int miscompares, cmp_count, ents, xents, ln, x;
    int ks[11] = '{0, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9};
    wsc_top #(.LINES(16), .OSC_CYCLES(OSC)) u_wsc_top (
        .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(pst), .prdata_o(prd),
        .pready_o(rdy), .pslverr_o(err), .wakeup_line_i(ln_v), .nmi_i(nmi),
        .ext_stop_n_i(xs_n), .cpu_write_i(cpw), .stop_request_o(sreq),
        .clock_run_o(crun), .shared_line_interrupt_channel_o(chan),
        .top_level_irq_o(tirq));
    wsc_partner u_wsc_partner (.clk_i(clk_i), .reset_i(reset_i), .clock_run_i(crun),
        .ack_i(ack), .cpu_write_o(cpw), .entries_o(ents));
    initial
        forever #4 clk_i = ~clk_i;
    task automatic chk(input logic [7:0] s, input logic [7:0] w);
        cmp_count++;
        if (s !== w)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, w);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // byte address is four times the register index
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d,
        output logic [7:0] q, output logic er);
        int n;
        @(posedge clk_i);
        psel <= 1'b1;
        pwr <= w;
        pa <= {2'b00, i, 2'b00};
        pwd <= {24'h000000, d};
        @(posedge clk_i);
        pen <= 1'b1;
        n = 0;
        @(posedge clk_i);
        while (rdy !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            n++;
        end
        q = prd[7:0];
        er = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] q;
        logic er;
        apb(1'b1, i, d, q, er);
    endtask
    task automatic rd(input logic [7:0] i);
        apb(1'b0, i, 8'h00, r, e);
    endtask
    task automatic wt();
        repeat (4) @(posedge clk_i);
    endtask
    // bit0 stop bit after the third write, bit1 stop entered
    function automatic int model(input int k);
        return ((k == 0 || k == 5) ? 3 : 0) | ((k == 1 || k == 9) ? 1 : 0);
    endfunction
    task automatic seq(input int k);
        logic md;
        md = (k != 8);
        if (k == 6)
        begin
            wr(ML, 8'h00);
            wr(MH, 8'h00);
        end
        if (k == 7)
            wr(PL, m16[7:0] | 8'h00);
        if (k == 7)
            wr(PH, m16[15:8]);
        if (k == 5 || k == 9)
            nmi <= 1'b1;
        wt();
        wr(CT, {5'h00, 2'b11, md});
        rd(CT);
        chk(r[2], 1'b1);
        wr(CT, {5'h00, 2'b01, md});
        if (k == 1)
        begin
            wr(MH, m16[15:8]);
            rd(CT);
            chk(r[2], 1'b0);
        end
        if (k == 5)
            nmi <= 1'b0;
        wr(CT, {5'h00, 2'b11, md});
        // injected inside the entry window, where the cpu would run its no-ops
        ack <= (k == 2);
        if (k == 3)
            ln_v[ln] <= 1'b0;
        if (k == 4)
            nmi <= 1'b1;
        @(posedge clk_i);
        ack <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic wake(input logic nm);
        int n;
        chk(sreq, 1'b1);
        ln_v[(ln + 1) % 16] <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk(crun, 1'b0);
        if (nm)
            nmi <= 1'b1;
        else
            ln_v[ln] <= 1'b0;
        n = 0;
        while (crun !== 1'b1 && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(n >= OSC && n < 100, 1'b1);
        rd(CT);
        chk(r[2], nm);
        rd(ST);
        chk(r[0], 1'b1);
    endtask
    // control first: the later writes also return a half-done sequence to idle
    task automatic tidy();
        wr(CT, 8'h03);
        wr(ST, 8'h05);
        wr(PL, 8'h00);
        wr(PH, 8'h00);
        rd(PL);
        chk(r, 8'h00);
        rd(PH);
        chk(r, 8'h00);
        wr(ML, m16[7:0]);
        wr(MH, m16[15:8]);
        rd(MH);
        chk(r, m16[15:8]);
        ln_v <= 16'hffff;
        nmi <= 1'b0;
        wt();
    endtask
    initial
    begin
        {psel, pen, pwr, nmi, ack} = 5'h00;
        {reset_i, xs_n} = 2'b11;
        pa = 12'h000;
        pwd = 32'h00000000;
        pst = 4'hf;
        ln_v = 16'hffff;
        ix = '{CT, ML, MH, PL, PH, ST, TP, wsc_pkg::IDX_POL_LOW, wsc_pkg::IDX_POL_HIGH};
        void'($urandom(32'hdad4));
        ln = $urandom_range(15, 0);
        m16 = 16'h0001 << ln;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        foreach (ix[i])
        begin
            rd(ix[i]);
            chk(r, 8'h00);
        end
        apb(1'b0, 8'h00, 8'h00, r, e);
        chk({7'h00, e}, 8'h01);
        chk(r, 8'h00);
        tidy();
        foreach (ks[i])
        begin
            x = model(ks[i]);
            seq(ks[i]);
            rd(CT);
            chk(r[2], x[0]);
            chk(crun, !x[1]);
            rd(ST);
            chk(r[1:0], {x[1], 1'b0});
            if (x[1])
            begin
                xents++;
                wake(i == 1);
            end
            tidy();
        end
        wr(CT, 8'h02);
        wr(ML, 8'h03);
        wr(PL, 8'h03);
        wt();
        chk(chan, 1'b1);
        wr(ST, 8'h04);
        wt();
        chk(chan, 1'b0);
        wr(PL, 8'h01);
        wt();
        chk(chan, 1'b1);
        wr(PL, 8'h00);
        wr(ST, 8'h04);
        wr(CT, 8'h00);
        wr(PL, 8'h03);
        wt();
        chk(chan, 1'b0);
        wr(TP, 8'h05);
        nmi <= 1'b1;
        wt();
        rd(TP);
        chk({r[2:1], tirq}, 3'b111);
        wr(TP, 8'h01);
        wt();
        rd(TP);
        chk({r[2:1], tirq}, 3'b100);
        nmi <= 1'b0;
        wt();
        nmi <= 1'b1;
        wt();
        chk(tirq, 1'b1);
        xs_n <= 1'b0;
        wt();
        chk(sreq, 1'b1);
        chk(8'(ents), 8'(xents));
        // a write with lane 0 strobe low must be dropped
        pst <= 4'h0;
        wr(ML, 8'hff);
        pst <= 4'hf;
        rd(ML);
        chk(r, 8'h03);
        // only reset may clear the sticky non-maskable select
        nmi <= 1'b0;
        wt();
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(TP);
        chk(r, 8'h00);
        wr(TP, 8'h09);
        nmi <= 1'b1;
        wt();
        chk(tirq, 1'b0);
        wr(TP, 8'h1b);
        wt();
        chk(tirq, 1'b1);
        close_out();
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        close_out();
    end
endmodule // wsc_top_tb
